// *** src/ebw_write_seq.sv ***
// Bus-master write-cycle sequencer for an asynchronous nonmultiplexed external bus
// ==========================================================
// Behaviour
// - Drive address and space code in S0
// - Drive write level and size in S0
// - Native style: address strobe in S1
// - Drive data in S2; sample acknowledges
// - Native: data strobe, write enables in S3
// - Acknowledge by S2 ends one clock later
// - No acknowledge: wait, sample every clock
// - Transfer done asserted during S4
// - S5 negates strobes, then transfer done
// - Address, data, controls held through S5
// - Legacy style uses its own strobes
// - Legacy data strobes assert as 16-bit
// - Word ack ends 16-bit, byte ack 8-bit
// - Legacy: S1 quiet, address strobe in S2
// - Legacy: data strobes, enables from S3
// - Acknowledge pair sampled gives port width
//
// One fabric clock edge stands for one half-clock bus state, so a
// zero-wait cycle is six CLK periods; a wait state is two CLK periods.
`timescale 1ns/1ps
`include "ebw_consts.svh"
module ebw_write_seq (
  input  wire logic                    CLK,
  input  wire logic                    RST,
  input  wire logic                    REQ_VALID,
  input  wire logic                    LEGACY_MODE,
  input  wire logic [`EBW_ADDR_W-1:0]  REQ_ADDR,
  input  wire logic [`EBW_DATA_W-1:0]  REQ_DATA,
  input  wire logic [`EBW_SPACE_W-1:0] REQ_SPACE,
  input  wire logic [`EBW_SIZE_W-1:0]  REQ_SIZE,
  input  wire logic                    SIZE_ACK_WORD_N,
  input  wire logic                    SIZE_ACK_BYTE_N,
  output logic                         REQ_READY,
  output logic [`EBW_ADDR_W-1:0]       ADDR,
  output logic [`EBW_SPACE_W-1:0]      SPACE_CODE,
  output logic [`EBW_SIZE_W-1:0]       TRANSFER_SIZE,
  output logic                         READ_WRITE,
  output logic [`EBW_DATA_W-1:0]       DATA_OUT,
  output logic                         DATA_OE_N,
  output logic                         ADDRESS_STROBE_N,
  output logic                         DATA_STROBE_N,
  output logic                         LEGACY_ADDRESS_STROBE_N,
  output logic                         UPPER_DATA_STROBE_N,
  output logic                         LOWER_DATA_STROBE_N,
  output logic                         UPPER_WRITE_ENABLE_N,
  output logic                         LOWER_WRITE_ENABLE_N,
  output logic                         TRANSFER_DONE_N,
  output logic                         DONE_PULSE,
  output logic                         PORT_WIDTH_16
);
  // ==========================================================
  // Acknowledge synchroniser
  logic [1:0] ack_sync;  // Synchronised {word, byte} acknowledges, active low

  ebw_sync #(.W(2)) u_ack_sync (
    .clk  (CLK),
    .rst  (RST),
    .din  ({SIZE_ACK_WORD_N, SIZE_ACK_BYTE_N}),
    .dout (ack_sync)
  );

  // Lane decode from size and low address bit; called once below, feeding both write enables
  function automatic logic [1:0] lanes_f(input logic [1:0] sz, input logic lab);
    logic [1:0] l;
    l = 2'h3;
    if (sz == `EBW_SIZE_BYTE) begin
      l = lab ? 2'h1 : 2'h2;  // Odd byte on lower lane, even on upper
    end
    return l;
  endfunction

  // ==========================================================
  // State and registered bus outputs
  ebw_pkg::ebw_state_e         st_q,   st_d;
  logic [`EBW_ADDR_W-1:0]      addr_q, addr_d;
  logic [`EBW_SPACE_W-1:0]     spc_q,  spc_d;
  logic [`EBW_SIZE_W-1:0]      siz_q,  siz_d;
  logic                        rw_q,   rw_d;
  logic [`EBW_DATA_W-1:0]      dat_q,  dat_d;
  logic                        doe_n_q, doe_n_d;
  logic                        legacy_q, legacy_d;   // Style latched per cycle
  logic                        adr_stb_n_q, adr_stb_n_d;      // Native address strobe
  logic                        dat_stb_n_q, dat_stb_n_d;      // Native data strobe
  logic                        las_n_q, las_n_d;
  logic                        up_stb_n_q, up_stb_n_d;        // Legacy upper data strobe
  logic                        lo_stb_n_q, lo_stb_n_d;        // Legacy lower data strobe
  logic                        up_wen_n_q, up_wen_n_d;        // Upper lane write enable
  logic                        lo_wen_n_q, lo_wen_n_d;        // Lower lane write enable
  logic                        xfer_done_n_q, xfer_done_n_d;  // Transfer done, active low
  logic                        wait_ph_q, wait_ph_d;          // Second half of a wait clock
  logic                        ack_seen_q, ack_seen_d;  // Acknowledge recognized
  logic                        pw16_q, pw16_d;
  logic                        done_q, done_d;
  logic                        rdy_q,  rdy_d;
  logic                        ack_any;
  logic [1:0]                  lanes;

  assign ack_any = ~(ack_sync[1] & ack_sync[0]);
  assign lanes   = lanes_f(siz_q, addr_q[0]);

  // Next-state and output computation
  always_comb begin
    st_d       = st_q;
    addr_d     = addr_q;
    spc_d      = spc_q;
    siz_d      = siz_q;
    rw_d       = rw_q;
    dat_d      = dat_q;
    doe_n_d    = doe_n_q;
    legacy_d   = legacy_q;
    adr_stb_n_d   = adr_stb_n_q;
    dat_stb_n_d   = dat_stb_n_q;
    las_n_d       = las_n_q;
    up_stb_n_d    = up_stb_n_q;
    lo_stb_n_d    = lo_stb_n_q;
    up_wen_n_d    = up_wen_n_q;
    lo_wen_n_d    = lo_wen_n_q;
    xfer_done_n_d = xfer_done_n_q;
    wait_ph_d     = wait_ph_q;
    ack_seen_d = ack_seen_q;
    pw16_d     = pw16_q;
    done_d     = 1'b0;
    rdy_d      = 1'b0;
    case (st_q)
      ebw_pkg::EBW_IDLE: begin
        // Take a request; the address phase starts next edge
        if (REQ_VALID && rdy_q) begin
          st_d     = ebw_pkg::EBW_S0;
          addr_d   = REQ_ADDR;
          spc_d    = REQ_SPACE;
          siz_d    = REQ_SIZE;
          rw_d     = 1'b0;
          dat_d    = REQ_DATA;
          legacy_d = LEGACY_MODE;
        end else begin
          rdy_d    = 1'b1;
        end
      end
      ebw_pkg::EBW_S0: begin
        st_d = ebw_pkg::EBW_S1;
        if (!legacy_q) begin
          adr_stb_n_d = 1'b0;
        end
        // Legacy style changes no control in S1
      end
      ebw_pkg::EBW_S1: begin
        st_d    = ebw_pkg::EBW_S2;
        doe_n_d = 1'b0;
        if (legacy_q) begin
          las_n_d = 1'b0;
        end
      end
      ebw_pkg::EBW_S2: begin
        // End of S2: sample acknowledges
        st_d       = ebw_pkg::EBW_S3;
        ack_seen_d = ack_any;
        pw16_d     = ~ack_sync[1];
        if (legacy_q) begin
          up_stb_n_d = 1'b0;  // Both strobes as for a 16-bit bus
          lo_stb_n_d = 1'b0;
        end else begin
          dat_stb_n_d = 1'b0;
        end
        up_wen_n_d = ~lanes[1];
        lo_wen_n_d = ~lanes[0];
      end
      ebw_pkg::EBW_S3: begin
        // Acknowledged: go on; else wait
        st_d = ack_seen_q ? ebw_pkg::EBW_S4 : ebw_pkg::EBW_SW;
        if (ack_seen_q) begin
          xfer_done_n_d = 1'b0;
        end
      end
      ebw_pkg::EBW_SW: begin
        // A wait state is a whole bus clock, sampled on its second half, so S4 keeps its phase
        wait_ph_d = ~wait_ph_q;
        if (wait_ph_q && ack_any) begin
          st_d          = ebw_pkg::EBW_S4;
          pw16_d        = ~ack_sync[1];
          xfer_done_n_d = 1'b0;
        end
      end
      ebw_pkg::EBW_S4: begin
        st_d    = ebw_pkg::EBW_S5;
        adr_stb_n_d = 1'b1;
        dat_stb_n_d = 1'b1;
        las_n_d     = 1'b1;
        up_stb_n_d  = 1'b1;
        lo_stb_n_d  = 1'b1;
        up_wen_n_d  = 1'b1;
        lo_wen_n_d  = 1'b1;
        // Address, data, size, space and write level held
      end
      ebw_pkg::EBW_S5: begin
        st_d    = ebw_pkg::EBW_IDLE;
        xfer_done_n_d = 1'b1;
        doe_n_d = 1'b1;
        rw_d    = 1'b1;
        done_d  = 1'b1;  // Port width valid with this pulse
        rdy_d   = 1'b1;
      end
      default: begin
        st_d = ebw_pkg::EBW_IDLE;
      end
    endcase
  end

  // Register the sequencer
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q       <= ebw_pkg::EBW_IDLE;
      addr_q     <= '0;
      spc_q      <= '0;
      siz_q      <= '0;
      rw_q       <= 1'b1;
      dat_q      <= '0;
      doe_n_q    <= 1'b1;
      legacy_q   <= 1'b0;
      adr_stb_n_q   <= 1'b1;
      dat_stb_n_q   <= 1'b1;
      las_n_q       <= 1'b1;
      up_stb_n_q    <= 1'b1;
      lo_stb_n_q    <= 1'b1;
      up_wen_n_q    <= 1'b1;
      lo_wen_n_q    <= 1'b1;
      xfer_done_n_q <= 1'b1;
      wait_ph_q     <= 1'b0;
      ack_seen_q <= 1'b0;
      pw16_q     <= `EBW_PORT_16;
      done_q     <= 1'b0;
      rdy_q      <= 1'b0;
    end else begin
      st_q       <= st_d;
      addr_q     <= addr_d;
      spc_q      <= spc_d;
      siz_q      <= siz_d;
      rw_q       <= rw_d;
      dat_q      <= dat_d;
      doe_n_q    <= doe_n_d;
      legacy_q   <= legacy_d;
      adr_stb_n_q   <= adr_stb_n_d;
      dat_stb_n_q   <= dat_stb_n_d;
      las_n_q       <= las_n_d;
      up_stb_n_q    <= up_stb_n_d;
      lo_stb_n_q    <= lo_stb_n_d;
      up_wen_n_q    <= up_wen_n_d;
      lo_wen_n_q    <= lo_wen_n_d;
      xfer_done_n_q <= xfer_done_n_d;
      wait_ph_q     <= wait_ph_d;
      ack_seen_q <= ack_seen_d;
      pw16_q     <= pw16_d;
      done_q     <= done_d;
      rdy_q      <= rdy_d;
    end
  end

  // ==========================================================
  // Outputs straight from flip-flops
  assign REQ_READY               = rdy_q;
  assign ADDR                    = addr_q;
  assign SPACE_CODE              = spc_q;
  assign TRANSFER_SIZE           = siz_q;
  assign READ_WRITE              = rw_q;
  assign DATA_OUT                = dat_q;
  assign DATA_OE_N               = doe_n_q;
  assign ADDRESS_STROBE_N        = adr_stb_n_q;
  assign DATA_STROBE_N           = dat_stb_n_q;
  assign LEGACY_ADDRESS_STROBE_N = las_n_q;
  assign UPPER_DATA_STROBE_N     = up_stb_n_q;
  assign LOWER_DATA_STROBE_N     = lo_stb_n_q;
  assign UPPER_WRITE_ENABLE_N    = up_wen_n_q;
  assign LOWER_WRITE_ENABLE_N    = lo_wen_n_q;
  assign TRANSFER_DONE_N         = xfer_done_n_q;
  assign DONE_PULSE              = done_q;
  assign PORT_WIDTH_16           = pw16_q;
endmodule // ebw_write_seq

// *** shared/ebw_consts.svh ***
// Bus widths and field constants for the external bus write sequencer
`ifndef EBW_CONSTS_SVH
`define EBW_CONSTS_SVH
`define EBW_ADDR_W      32
`define EBW_DATA_W      16
`define EBW_SPACE_W     4
`define EBW_SIZE_W      2
`define EBW_SIZE_BYTE   2'h1
`define EBW_SIZE_WORD   2'h2
`define EBW_PORT_16     1'h1
`define EBW_PORT_8      1'h0
`endif

// *** shared/ebw_pkg.sv ***
// Types shared by the external bus write sequencer
package ebw_pkg;
  // Half-clock bus states; wait states sit between S3 and S4
  typedef enum logic [2:0] {
    EBW_IDLE,
    EBW_S0,
    EBW_S1,
    EBW_S2,
    EBW_S3,
    EBW_SW,
    EBW_S4,
    EBW_S5
  } ebw_state_e;
endpackage

// *** src/ebw_sync.sv ***
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module ebw_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  // ==========================================================
  // Synchroniser stages
  logic [W-1:0] meta_q;  // First stage, read only by the second
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;  // Second stage, safe to use
  logic [W-1:0] sync_d;

  // Next values: shift the input through
  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  // Register both stages; idle high matches negated active-low strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule // ebw_sync

// *** verification/ebw_write_seq_checker.sv ***
// Pin assertions for the external bus write sequencer
`timescale 1ns/1ps
`include "ebw_consts.svh"
module ebw_write_seq_checker (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        REQ_READY,
  input wire logic        LEGACY_MODE,
  input wire logic [31:0] REQ_ADDR,
  input wire logic [3:0]  REQ_SPACE,
  input wire logic [1:0]  REQ_SIZE,
  input wire logic        SIZE_ACK_WORD_N,
  input wire logic        SIZE_ACK_BYTE_N,
  input wire logic [31:0] ADDR,
  input wire logic [3:0]  SPACE_CODE,
  input wire logic [1:0]  TRANSFER_SIZE,
  input wire logic        READ_WRITE,
  input wire logic [15:0] DATA_OUT,
  input wire logic        DATA_OE_N,
  input wire logic        ADDRESS_STROBE_N,
  input wire logic        DATA_STROBE_N,
  input wire logic        LEGACY_ADDRESS_STROBE_N,
  input wire logic        UPPER_DATA_STROBE_N,
  input wire logic        LOWER_DATA_STROBE_N,
  input wire logic        UPPER_WRITE_ENABLE_N,
  input wire logic        LOWER_WRITE_ENABLE_N,
  input wire logic        TRANSFER_DONE_N,
  input wire logic        DONE_PULSE,
  input wire logic        PORT_WIDTH_16
);
  // Some acknowledge at the pins
  wire ack_any = !(SIZE_ACK_WORD_N && SIZE_ACK_BYTE_N);
  // Byte write leaves this lane alone
  wire skip_up = TRANSFER_SIZE == `EBW_SIZE_BYTE && ADDR[0];
  wire skip_lo = TRANSFER_SIZE == `EBW_SIZE_BYTE && !ADDR[0];
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ==========================================
  // Cycle sequence
  addr_space_a: assert property (
    $fell(READ_WRITE) |-> ADDR == $past(REQ_ADDR) && SPACE_CODE == $past(REQ_SPACE))
    else $error("bad address in S0");
  write_start_a: assert property (
    $fell(READ_WRITE) |-> $past(REQ_READY) && TRANSFER_SIZE == $past(REQ_SIZE))
    else $error("bad size in S0");
  native_strobe_a: assert property (
    $fell(READ_WRITE) && !$past(LEGACY_MODE) |=> $fell(ADDRESS_STROBE_N))
    else $error("address strobe late");
  legacy_strobe_a: assert property (
    $fell(READ_WRITE) && $past(LEGACY_MODE) |=> ADDRESS_STROBE_N && LEGACY_ADDRESS_STROBE_N
    ##1 !LEGACY_ADDRESS_STROBE_N && !DATA_OE_N && ADDRESS_STROBE_N)
    else $error("legacy strobe timing");
  data_strobe_a: assert property (
    $fell(DATA_STROBE_N) |-> !$past(DATA_OE_N) && !ADDRESS_STROBE_N)
    else $error("data strobe before data");
  lane_enable_a: assert property (
    $fell(DATA_STROBE_N) || $fell(UPPER_DATA_STROBE_N) |-> UPPER_WRITE_ENABLE_N == skip_up
    && LOWER_WRITE_ENABLE_N == skip_lo && UPPER_DATA_STROBE_N == LOWER_DATA_STROBE_N)
    else $error("wrong lane enables");
  zero_wait_a: assert property (
    $fell(READ_WRITE) && ack_any |-> ##4 $fell(TRANSFER_DONE_N))
    else $error("zero wait cycle late");
  wait_ack_a: assert property (
    $fell(TRANSFER_DONE_N) |-> $past(ack_any, 3))
    else $error("ended without acknowledge");
  s5_hold_a: assert property (
    $fell(TRANSFER_DONE_N) |=> ADDRESS_STROBE_N && DATA_STROBE_N && UPPER_DATA_STROBE_N
    && !TRANSFER_DONE_N && !READ_WRITE && $stable(ADDR) && $stable(DATA_OUT) && $stable(SPACE_CODE)
    && $stable(TRANSFER_SIZE) ##1 TRANSFER_DONE_N && DONE_PULSE)
    else $error("bad S5");
  port_width_a: assert property (
    DONE_PULSE |-> PORT_WIDTH_16 != $past(SIZE_ACK_WORD_N, 5))
    else $error("wrong port width");
endmodule // ebw_write_seq_checker

bind ebw_write_seq ebw_write_seq_checker i_ebw_write_seq_checker (.*);

// *** verification/ebw_slave_model.sv ***
// Memory slave that ends write cycles with a size acknowledge
`timescale 1ns/1ps
`include "ebw_consts.svh"
module ebw_slave_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        read_write,
  input  wire logic        addr_low,
  input  wire logic [1:0]  size,
  input  wire logic [15:0] data,
  input  wire logic        data_strobe_n,
  input  wire logic        upper_ds_n,
  input  wire logic        upper_we_n,
  input  wire logic        lower_we_n,
  input  wire logic [31:0] ack_delay,
  input  wire logic        ack_byte,
  output logic             ack_word_n,
  output logic             ack_byte_n,
  output logic [15:0]      mem_q
);
  // Cycles since the write level went low
  int  cnt_q;
  wire ack = !read_write && cnt_q >= ack_delay;
  // Native lane choice from size and low address bit
  wire up  = size != `EBW_SIZE_BYTE || !addr_low;
  wire lo  = size != `EBW_SIZE_BYTE || addr_low;
  // Pulled up until ready; held until the write level returns high, then released
  assign ack_word_n = !(ack && !ack_byte);
  assign ack_byte_n = !(ack && ack_byte);
  // ==========================================
  // Store the enabled lanes
  always_ff @(posedge clk) begin
    cnt_q <= read_write ? 0 : cnt_q + 1;
    if (rst) begin
      mem_q <= 16'h0;
    end else begin
      if ((!data_strobe_n && up) || (!upper_ds_n && !upper_we_n)) mem_q[15:8] <= data[15:8];
      if ((!data_strobe_n && lo) || (!upper_ds_n && !lower_we_n)) mem_q[7:0] <= data[7:0];
    end
  end
endmodule // ebw_slave_model

// *** verification/test_ebw_write_seq.sv ***
// Self-checking testbench for the external bus write sequencer
`timescale 1ns/1ps
`include "ebw_consts.svh"
module test_ebw_write_seq;
  logic        CLK, RST, REQ_VALID, LEGACY_MODE, REQ_READY, READ_WRITE, DATA_OE_N, DONE_PULSE;
  logic        ADDRESS_STROBE_N, DATA_STROBE_N, LEGACY_ADDRESS_STROBE_N, UPPER_DATA_STROBE_N;
  logic        LOWER_DATA_STROBE_N, UPPER_WRITE_ENABLE_N, LOWER_WRITE_ENABLE_N, TRANSFER_DONE_N;
  logic        PORT_WIDTH_16, SIZE_ACK_WORD_N, SIZE_ACK_BYTE_N, ack_byt;
  logic [31:0] REQ_ADDR, ADDR;
  logic [15:0] REQ_DATA, DATA_OUT, mem, exp_mem;
  logic [3:0]  REQ_SPACE, SPACE_CODE;
  logic [1:0]  REQ_SIZE, TRANSFER_SIZE;
  int          ack_dly, failures, checks;
  ebw_write_seq i_ebw_write_seq (.*);
  ebw_slave_model i_ebw_slave_model (.clk(CLK), .rst(RST), .read_write(READ_WRITE), .addr_low(ADDR[0]),
    .size(TRANSFER_SIZE), .data(DATA_OUT), .data_strobe_n(DATA_STROBE_N), .upper_ds_n(UPPER_DATA_STROBE_N),
    .upper_we_n(UPPER_WRITE_ENABLE_N), .lower_we_n(LOWER_WRITE_ENABLE_N), .ack_delay(ack_dly),
    .ack_byte(ack_byt), .ack_word_n(SIZE_ACK_WORD_N), .ack_byte_n(SIZE_ACK_BYTE_N), .mem_q(mem));
  // ==========================================
  // Clock, 50 ns period
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  // Bound ran out
  task automatic to();
    failures++;
    $display("mismatch at %0t: timeout", $time);
    finish_test();
  endtask
  // One write cycle; fresh requests are offered while busy and must be ignored
  task automatic wr(input logic lg, input logic [1:0] sz, input logic [31:0] ad, input logic [15:0] dt,
                    input int d, input logic byt);
    int n;
    int w;
    n = 0;
    while (REQ_READY !== 1'b1) begin
      @(negedge CLK);
      n++;
      if (n > 40) to();
    end
    {LEGACY_MODE, REQ_SIZE, REQ_ADDR, REQ_DATA, REQ_SPACE} = {lg, sz, ad, dt, 4'h5};
    ack_dly = d;
    ack_byt = byt;
    REQ_VALID = 1'b1;
    @(negedge CLK);
    REQ_VALID = 1'b0;
    REQ_DATA = ~dt;
    @(negedge CLK);
    chk(ADDR, ad, "address");
    chk(32'(SPACE_CODE), 32'h5, "space code");
    chk(32'({READ_WRITE, TRANSFER_SIZE}), 32'({1'b0, sz}), "size");
    n = 1;
    while (DONE_PULSE !== 1'b1) begin
      REQ_VALID = n < 4;
      @(negedge CLK);
      n++;
      if (n > 60) to();
    end
    // Acks reach the sequencer two edges after the pins; a wait state is one whole bus clock
    w = (d == 0) ? 0 : ((d < 2) ? 1 : d / 2);
    chk(n, 6 + 2 * w, "latency");
    chk(32'(PORT_WIDTH_16), 32'(!byt), "port width");
    if (sz != `EBW_SIZE_BYTE || !ad[0]) exp_mem[15:8] = dt[15:8];
    if (sz != `EBW_SIZE_BYTE || ad[0]) exp_mem[7:0] = dt[7:0];
    chk(32'(mem), 32'(exp_mem), "stored data");
  endtask
  task automatic t_native();
    wr(1'b0, 2'h2, 32'h1000_0000, 16'ha5c3, 0, 1'b0);
    wr(1'b0, 2'h1, 32'h1000_0002, 16'h1234, 0, 1'b1);
    wr(1'b0, 2'h1, 32'hffff_ffff, 16'h5678, 0, 1'b1);
    $display("test native done");
  endtask
  task automatic t_wait();
    wr(1'b0, 2'h2, 32'h0000_0100, 16'h0f1e, 2, 1'b0);
    wr(1'b0, 2'h3, 32'h0000_0101, 16'hc33c, 6, 1'b1);
    $display("test wait done");
  endtask
  task automatic t_legacy();
    wr(1'b1, 2'h2, 32'h2000_0000, 16'hbeef, 0, 1'b0);
    wr(1'b1, 2'h1, 32'h2000_0001, 16'h9a00, 2, 1'b1);
    wr(1'b1, 2'h0, 32'h2000_0004, 16'h4d2b, 6, 1'b0);
    $display("test legacy done");
  endtask
  // Reset in mid-cycle, then a clean cycle
  task automatic t_reset_mid();
    REQ_VALID = 1'b1;
    @(negedge CLK);
    REQ_VALID = 1'b0;
    repeat (4) @(negedge CLK);
    RST = 1'b1;
    @(negedge CLK);
    RST = 1'b0;
    exp_mem = 16'h0;
    chk(32'({ADDRESS_STROBE_N, DATA_STROBE_N, READ_WRITE, REQ_READY}), 32'he, "reset state");
    wr(1'b0, 2'h2, 32'h0000_0a10, 16'h0ff0, 0, 1'b0);
    $display("test reset_mid done");
  endtask
  initial begin
    {RST, REQ_VALID, LEGACY_MODE, ack_byt, REQ_ADDR, REQ_DATA, REQ_SPACE, REQ_SIZE} = {4'h8, 54'h0};
    {ack_dly, failures, checks, exp_mem} = '0;
    repeat (8) @(negedge CLK);
    RST = 1'b0;
    t_native();
    t_wait();
    t_legacy();
    t_reset_mid();
    finish_test();
  end
endmodule // test_ebw_write_seq
